//--- rtl/occ_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef OCC_DEFS_SVH
`define OCC_DEFS_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OCC_SLOW_OFS 6'h18
`define OCC_ULP_OFS 6'h1C
`define OCC_FAST_OFS 6'h20
`define OCC_LOOP_OFS 6'h24
// ----------------------------------------------------------------------
// common field positions
// ----------------------------------------------------------------------
`define OCC_ON_REQ_BIT 7
`define OCC_STDBY_BIT 6
`define OCC_EN_BIT 1
// ----------------------------------------------------------------------
// slow rc fields
// ----------------------------------------------------------------------
`define OCC_SLOW_1K_BIT 3
`define OCC_SLOW_32K_BIT 2
`define OCC_SLOW_LOCK_BIT 12
`define OCC_SLOW_RST 32'h003F0080
`define OCC_SLOW_WMASK 32'h007F17CE
// ----------------------------------------------------------------------
// ultra low power fields
// ----------------------------------------------------------------------
`define OCC_ULP_LOCK_BIT 7
`define OCC_ULP_WMASK 8'h9F
// ----------------------------------------------------------------------
// fast rc fields
// ----------------------------------------------------------------------
`define OCC_FAST_RST_LOW 16'h0382
`define OCC_FAST_WMASK 32'hCFFF03C2
// ----------------------------------------------------------------------
// loop control fields
// ----------------------------------------------------------------------
`define OCC_LOOP_RST 16'h0080
`define OCC_LOOP_WMASK 16'h0FFE
`define OCC_LOOP_MODE_BIT 2
`define OCC_LOOP_STABLE_BIT 3
`define OCC_LOOP_DROP_LOCK_ON_WAKE_BIT 4
`define OCC_LOOP_SKIP_BIT 10
`define OCC_LOOP_WAIT_BIT 11
// ----------------------------------------------------------------------
// timing: fast oscillator settle time and loop enable sync delay
// ----------------------------------------------------------------------
`define OCC_FAST_SETTLE_NS 2000
`define OCC_CLK_NS 40
`define OCC_FAST_SETTLE_CYC ((`OCC_FAST_SETTLE_NS + `OCC_CLK_NS - 1) / `OCC_CLK_NS)
`define OCC_LOOP_SYNC_CYC 3
`endif

//--- rtl/occ_pkg.sv
// types for the oscillator control block
package occ_pkg;
   typedef enum logic [1:0] {
      OCC_FAST_OFF,
      OCC_FAST_STARTING,
      OCC_FAST_ON,
      OCC_FAST_STOPPING
   } occ_fast_state_t;
endpackage

//--- rtl/occ_osc_ctrl.sv
// oscillator control registers with on-demand run logic
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "occ_defs.svh"
// Contract
// - on-demand set: oscillator runs only while some peripheral requests it
// - on-demand clear: enabled oscillator runs continuously
// - standby with keep-in-standby clear: oscillator stopped
// - standby with keep-in-standby set: on-demand logic still applies
// - slow oscillator outputs 1k and 32k gated by bits 3 and 2
// - reserved bits read zero; software writes zeros
// - ultra low power lock bit locks that register against writes
// - ultra low power trim loaded from flash at startup
// - fast oscillator range from bits 31:30, loaded at startup
// - fast trim 27:16: upper six temperature, lower six process
// - fast output divided by 1, 2, 4 or 8 from bits 9:8
// - fast enable reads zero off or starting, one on or stopping
// - hold-until-locked gates loop output until locked
// - skip-coarse-lock bypasses coarse locking
// - loop control bit 2 selects open or closed loop
// - loop enable reads back at once; effect after sync delay
// - stable bit freezes fine trim after fine lock
// - drop-lock-on-wake drops locks after wake if loop clock stopped
module occ_osc_ctrl
   import occ_pkg::*;
#(
   parameter int NUM_REQ = 4,
   parameter int FAST_SETTLE = `OCC_FAST_SETTLE_CYC,
   parameter int LOOP_SYNC = `OCC_LOOP_SYNC_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic avs_response_err,
   input wire logic [7:0] cal_ulp_trim,
   input wire logic [11:0] cal_fast_trim,
   input wire logic [1:0] cal_fast_range,
   input wire logic cal_valid,
   input wire logic standby,
   input wire logic wake_event,
   input wire logic [NUM_REQ-1:0] slow_req,
   input wire logic [NUM_REQ-1:0] fast_req,
   input wire logic [NUM_REQ-1:0] loop_req,
   input wire logic loop_locked,
   input wire logic loop_clk_stopped,
   output logic slow_run,
   output logic slow_out_1k_enable,
   output logic slow_out_32k_enable,
   output logic [4:0] ulp_trim_value,
   output logic fast_run,
   output logic [1:0] fast_freq_range_sel,
   output logic [5:0] fast_temp_trim,
   output logic [5:0] fast_process_trim,
   output logic [3:0] fast_div_factor,
   output logic loop_run,
   output logic loop_out_gate,
   output logic loop_closed,
   output logic loop_skip_coarse_lock,
   output logic loop_freeze_fine,
   output logic loop_quick_lock_off,
   output logic loop_chill_cycle_off,
   output logic loop_bus_clock_recovery,
   output logic loop_drop_locks
);
   // settle counter is 16 bits, so longer settle times cannot be served
   if (NUM_REQ < 1 || FAST_SETTLE < 1 || FAST_SETTLE > 65536 ||
      LOOP_SYNC < 1) begin : g_bad_param
      $error("occ_osc_ctrl: parameter out of range");
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic [31:0] slow_ctrl_ff, nxt_slow_ctrl;
   logic [7:0] ulp_ctrl_ff, nxt_ulp_ctrl;
   logic [31:0] fast_ctrl_ff, nxt_fast_ctrl;
   logic [15:0] loop_ctrl_ff, nxt_loop_ctrl;
   logic cal_done_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic err_ff;
   occ_fast_state_t fast_state_ff, nxt_fast_state;
   logic [15:0] fast_cnt_ff, nxt_fast_cnt;
   logic [LOOP_SYNC-1:0] loop_sync_ff;
   logic std_ff, std_d_ff;
   logic [1:0] cal_sync_ff;

   // ----------------------------------------------------------------------
   // bus decode: one wait cycle, answer on the second
   // ----------------------------------------------------------------------
   wire req = (avs_read | avs_write) & clk_en;
   wire take = req & ~ack_ff;
   wire hit_slow = avs_address == `OCC_SLOW_OFS;
   wire hit_ulp = avs_address == `OCC_ULP_OFS;
   wire hit_fast = avs_address == `OCC_FAST_OFS;
   wire hit_loop = avs_address == `OCC_LOOP_OFS;
   wire hit_any = hit_slow | hit_ulp | hit_fast | hit_loop;
   wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire slow_locked = slow_ctrl_ff[`OCC_SLOW_LOCK_BIT];
   wire ulp_locked = ulp_ctrl_ff[`OCC_ULP_LOCK_BIT];
   // a locked register still answers; only the write is dropped
   wire wr_slow = take & avs_write & hit_slow & ~slow_locked;
   wire wr_ulp = take & avs_write & hit_ulp & ~ulp_locked;
   wire wr_fast = take & avs_write & hit_fast;
   wire wr_loop = take & avs_write & hit_loop;
   wire [31:0] m_slow = `OCC_SLOW_WMASK & be_mask;
   wire [31:0] m_fast = `OCC_FAST_WMASK & be_mask;
   wire [7:0] m_ulp = `OCC_ULP_WMASK & be_mask[7:0];
   wire [15:0] m_loop = `OCC_LOOP_WMASK & be_mask[15:0];

   // reserved bits never stored, so they always read zero
   assign nxt_slow_ctrl = wr_slow ?
      (slow_ctrl_ff & ~m_slow) | (avs_writedata & m_slow) :
      slow_ctrl_ff;
   assign nxt_ulp_ctrl = wr_ulp ?
      (ulp_ctrl_ff & ~m_ulp) | (avs_writedata[7:0] & m_ulp) :
      ulp_ctrl_ff;
   assign nxt_loop_ctrl = wr_loop ?
      (loop_ctrl_ff & ~m_loop) | (avs_writedata[15:0] & m_loop) :
      loop_ctrl_ff;
   // startup load of calibration wins only in the capture cycle
   wire cal_load = cal_sync_ff[1] & ~cal_done_ff;
   wire [31:0] fast_cal_word = {cal_fast_range, 2'h0, cal_fast_trim,
      fast_ctrl_ff[15:0]};
   assign nxt_fast_ctrl = cal_load ? fast_cal_word :
      wr_fast ? (fast_ctrl_ff & ~m_fast) | (avs_writedata & m_fast) :
      fast_ctrl_ff;

   // fast enable reads the running state, not the written bit
   wire fast_en_rd = fast_state_ff == OCC_FAST_ON ||
      fast_state_ff == OCC_FAST_STOPPING;
   wire [31:0] fast_rd = {fast_ctrl_ff[31:2], fast_en_rd,
      fast_ctrl_ff[0]};
   wire [31:0] rd_mux = hit_slow ? slow_ctrl_ff :
      hit_ulp ? {24'h000000, ulp_ctrl_ff} :
      hit_fast ? fast_rd :
      hit_loop ? {16'h0000, loop_ctrl_ff} : 32'h00000000;
   // wait held while frozen unless ack_ff was set, when a new request gets the old answer
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign avs_readdata = rdata_ff;
   assign avs_response_err = err_ff;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         err_ff <= 1'b0;
      end else if (clk_en) begin
         ack_ff <= take;
         if (take) begin
            rdata_ff <= avs_read ? rd_mux : 32'h00000000;
            err_ff <= ~hit_any;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         slow_ctrl_ff <= `OCC_SLOW_RST;
         ulp_ctrl_ff <= 8'h00;
         fast_ctrl_ff <= {16'h0000, `OCC_FAST_RST_LOW};
         loop_ctrl_ff <= `OCC_LOOP_RST;
      end else if (clk_en) begin
         slow_ctrl_ff <= nxt_slow_ctrl;
         ulp_ctrl_ff <= cal_load ? {3'h0, cal_ulp_trim[4:0]} :
            nxt_ulp_ctrl;
         fast_ctrl_ff <= nxt_fast_ctrl;
         loop_ctrl_ff <= nxt_loop_ctrl;
      end
   end

   // ----------------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cal_sync_ff <= 2'h0;
         cal_done_ff <= 1'b0;
         std_ff <= 1'b0;
         std_d_ff <= 1'b0;
      end else if (clk_en) begin
         cal_sync_ff <= {cal_sync_ff[0], cal_valid};
         if (cal_sync_ff[1]) begin
            cal_done_ff <= 1'b1;
         end
         std_ff <= standby;
         std_d_ff <= std_ff;
      end
   end
   // ----------------------------------------------------------------------
   // run decision shared by the slow, fast and loop oscillators
   // ----------------------------------------------------------------------
   function automatic logic run_calc(input logic en, input logic ond,
      input logic rstd, input logic std, input logic any_req);
      logic demand_ok;
      demand_ok = ~ond | any_req;
      run_calc = en & demand_ok & (~std | rstd);
   endfunction
   wire slow_any = |slow_req;
   wire fast_any = |fast_req;
   wire loop_any = |loop_req;
   wire slow_want = run_calc(slow_ctrl_ff[`OCC_EN_BIT],
      slow_ctrl_ff[`OCC_ON_REQ_BIT], slow_ctrl_ff[`OCC_STDBY_BIT],
      std_d_ff, slow_any);
   wire fast_want = run_calc(fast_ctrl_ff[`OCC_EN_BIT],
      fast_ctrl_ff[`OCC_ON_REQ_BIT], fast_ctrl_ff[`OCC_STDBY_BIT],
      std_d_ff, fast_any);
   // loop follows the delayed enable, so its run lags the readback
   wire loop_want = run_calc(loop_sync_ff[LOOP_SYNC-1],
      loop_ctrl_ff[`OCC_ON_REQ_BIT], loop_ctrl_ff[`OCC_STDBY_BIT],
      std_d_ff, loop_any);

   // ----------------------------------------------------------------------
   // fast oscillator start and stop sequence
   // ----------------------------------------------------------------------
   // sequence follows the enable bit, not the demand gating
   wire fast_en = fast_ctrl_ff[`OCC_EN_BIT];
   wire cnt_done = fast_cnt_ff == 16'h0000;
   wire [15:0] settle = 16'(FAST_SETTLE - 1);
   always_comb begin
      nxt_fast_state = fast_state_ff;
      nxt_fast_cnt = cnt_done ? 16'h0000 : fast_cnt_ff - 16'h0001;
      unique case (fast_state_ff)
         OCC_FAST_OFF: begin
            if (fast_en) begin
               nxt_fast_state = OCC_FAST_STARTING;
               nxt_fast_cnt = settle;
            end
         end
         OCC_FAST_STARTING: begin
            if (cnt_done) begin
               nxt_fast_state = OCC_FAST_ON;
            end
         end
         OCC_FAST_ON: begin
            if (!fast_en) begin
               nxt_fast_state = OCC_FAST_STOPPING;
               nxt_fast_cnt = settle;
            end
         end
         OCC_FAST_STOPPING: begin
            if (cnt_done) begin
               nxt_fast_state = OCC_FAST_OFF;
            end
         end
      endcase
   end

   // reset leaves enable set, so the oscillator starts out settled
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fast_state_ff <= OCC_FAST_ON;
         fast_cnt_ff <= 16'h0000;
      end else if (clk_en) begin
         fast_state_ff <= nxt_fast_state;
         fast_cnt_ff <= nxt_fast_cnt;
      end
   end
   // ----------------------------------------------------------------------
   // loop enable sync delay; readback comes straight from the register
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         loop_sync_ff <= '0;
      end else if (clk_en) begin
         loop_sync_ff <= LOOP_SYNC'({loop_sync_ff,
            loop_ctrl_ff[`OCC_EN_BIT]});
      end
   end

   // ----------------------------------------------------------------------
   // outputs, all registered
   // ----------------------------------------------------------------------
   wire [1:0] div_sel = fast_ctrl_ff[9:8];
   wire [3:0] nxt_div_factor = 4'h1 << div_sel;
   wire wake_lost = wake_event & loop_clk_stopped &
      loop_ctrl_ff[`OCC_LOOP_DROP_LOCK_ON_WAKE_BIT];
   wire gate_ok = ~loop_ctrl_ff[`OCC_LOOP_WAIT_BIT] | loop_locked;

   // slow rc and ultra low power outputs
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         slow_run <= 1'b0;
         slow_out_1k_enable <= 1'b0;
         slow_out_32k_enable <= 1'b0;
         ulp_trim_value <= 5'h00;
      end else if (clk_en) begin
         slow_run <= slow_want;
         slow_out_1k_enable <= slow_want &
            slow_ctrl_ff[`OCC_SLOW_1K_BIT];
         slow_out_32k_enable <= slow_want &
            slow_ctrl_ff[`OCC_SLOW_32K_BIT];
         ulp_trim_value <= ulp_ctrl_ff[4:0];
      end
   end

   // fast rc outputs; trims follow the register, so rewrites act at once
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fast_run <= 1'b0;
         fast_freq_range_sel <= 2'h0;
         fast_temp_trim <= 6'h00;
         fast_process_trim <= 6'h00;
         fast_div_factor <= 4'h1;
      end else if (clk_en) begin
         fast_run <= fast_want;
         fast_freq_range_sel <= fast_ctrl_ff[31:30];
         fast_temp_trim <= fast_ctrl_ff[27:22];
         fast_process_trim <= fast_ctrl_ff[21:16];
         fast_div_factor <= nxt_div_factor;
      end
   end

   // loop outputs; the drop pulse lasts one cycle per wake cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         loop_run <= 1'b0;
         loop_out_gate <= 1'b0;
         loop_closed <= 1'b0;
         loop_skip_coarse_lock <= 1'b0;
         loop_freeze_fine <= 1'b0;
         loop_quick_lock_off <= 1'b0;
         loop_chill_cycle_off <= 1'b0;
         loop_bus_clock_recovery <= 1'b0;
         loop_drop_locks <= 1'b0;
      end else if (clk_en) begin
         loop_run <= loop_want;
         loop_out_gate <= loop_want & gate_ok;
         loop_closed <= loop_ctrl_ff[`OCC_LOOP_MODE_BIT];
         loop_skip_coarse_lock <= loop_ctrl_ff[`OCC_LOOP_SKIP_BIT];
         loop_freeze_fine <= loop_ctrl_ff[`OCC_LOOP_STABLE_BIT];
         loop_quick_lock_off <= loop_ctrl_ff[9];
         loop_chill_cycle_off <= loop_ctrl_ff[8];
         loop_bus_clock_recovery <= loop_ctrl_ff[5];
         loop_drop_locks <= wake_lost;
      end
   end
endmodule

//--- sim/occ_chk_sva.sv
// port-level assertions for the oscillator control block
`timescale 1ns/100ps
`include "occ_defs.svh"
module occ_chk (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic avs_response_err,
   input wire logic wake_event,
   input wire logic loop_clk_stopped,
   input wire logic [4:0] ulp_trim_value,
   input wire logic [1:0] fast_freq_range_sel,
   input wire logic [5:0] fast_temp_trim,
   input wire logic [5:0] fast_process_trim,
   input wire logic [3:0] fast_div_factor,
   input wire logic loop_run,
   input wire logic loop_out_gate,
   input wire logic loop_drop_locks
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   wire req = avs_read | avs_write;
   wire rd_done = avs_read & ~avs_waitrequest;
   wire at_ulp = avs_address == `OCC_ULP_OFS;
   wire at_fast = avs_address == `OCC_FAST_OFS;
   // unmapped places count as wholly reserved, so they read zero too
   wire [31:0] rsv = avs_address == `OCC_SLOW_OFS ? ~`OCC_SLOW_WMASK :
      at_ulp ? ~{24'h0, `OCC_ULP_WMASK} : at_fast ? ~`OCC_FAST_WMASK :
      avs_address == `OCC_LOOP_OFS ? ~{16'h0, `OCC_LOOP_WMASK} : 32'hFFFFFFFF;
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_fresh;
      req && avs_waitrequest;
   endsequence
   sequence s_answer;
      req && !avs_waitrequest;
   endsequence
   a_wait_one: assert property (s_fresh |=> s_answer)
      else $error("no answer one cycle after request");
   a_idle_free: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest without request");
   a_unmapped_err: assert property (s_answer |->
      avs_response_err == (rsv == 32'hFFFFFFFF))
      else $error("error response wrong for address");
   a_reserved_zero: assert property (
      rd_done |-> (avs_readdata & rsv) == 32'h0)
      else $error("reserved bits read nonzero");
   a_ulp_trim: assert property (
      rd_done && at_ulp |-> ulp_trim_value == avs_readdata[4:0])
      else $error("trim output differs from register");
   a_fast_fields: assert property (rd_done && at_fast |->
      fast_freq_range_sel == avs_readdata[31:30] &&
      {fast_temp_trim, fast_process_trim} == avs_readdata[27:16])
      else $error("range or trim output differs from register");
   a_div_factor: assert property (rd_done && at_fast |->
      fast_div_factor == 4'h1 << avs_readdata[9:8])
      else $error("divider output differs from code");
   a_drop_cause: assert property (loop_drop_locks |->
      $past(wake_event) && $past(loop_clk_stopped))
      else $error("locks dropped without stopped wake");
   a_gate_run: assert property (
      loop_out_gate |-> loop_run)
      else $error("loop output gated on while loop stopped");
endmodule
bind occ_osc_ctrl occ_chk i_chk (.sys_clk, .resetn, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .avs_response_err,
   .wake_event, .loop_clk_stopped, .ulp_trim_value, .fast_freq_range_sel,
   .fast_temp_trim, .fast_process_trim, .fast_div_factor, .loop_run,
   .loop_out_gate, .loop_drop_locks);

//--- sim/occ_req_model.sv
// peripheral clock requesters for the on-demand oscillators
`timescale 1ns/100ps
module occ_req_model #(
   parameter int NUM_REQ = 4
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [2:0] want,
   output logic [NUM_REQ-1:0] slow_req,
   output logic [NUM_REQ-1:0] fast_req,
   output logic [NUM_REQ-1:0] loop_req
);
   logic [NUM_REQ-1:0] r [3];
   int lag [3];
   assign slow_req = r[0];
   assign fast_req = r[1];
   assign loop_req = r[2];
   // random lag mimics prompt and slow peripherals; pattern held while wanted
   always @(posedge sys_clk or negedge resetn) begin
      for (int i = 0; i < 3; i++) begin
         if (!resetn || !want[i]) begin
            r[i] <= '0;
            lag[i] <= $urandom_range(6);
         end else if (lag[i] > 0) begin
            lag[i] <= lag[i] - 1;
         end else if (r[i] == '0) begin
            r[i] <= NUM_REQ'($urandom) | NUM_REQ'(1);
         end
      end
   end
endmodule

//--- sim/tb_top.sv
// self-checking bench for the oscillator control block
`timescale 1ns/100ps
`include "occ_defs.svh"
module tb_top;
   localparam int NR = 4;
   logic sys_clk, resetn, clk_en, avs_read, avs_write, avs_waitrequest;
   logic avs_response_err, cal_valid, standby, wake_event, eq, er;
   logic loop_locked, loop_clk_stopped, slow_run, fast_run, loop_run;
   logic slow_out_1k_enable, slow_out_32k_enable, loop_out_gate, loop_closed;
   logic loop_skip_coarse_lock, loop_freeze_fine, loop_quick_lock_off;
   logic loop_chill_cycle_off, loop_bus_clock_recovery, loop_drop_locks;
   logic [31:0] avs_writedata, avs_readdata, rq;
   logic [5:0] avs_address, fast_temp_trim, fast_process_trim;
   logic [3:0] avs_byteenable, fast_div_factor;
   logic [1:0] cal_fast_range, fast_freq_range_sel;
   logic [7:0] cal_ulp_trim;
   logic [11:0] cal_fast_trim;
   logic [4:0] ulp_trim_value;
   logic [NR-1:0] slow_req, fast_req, loop_req;
   logic [2:0] want;
   logic [31:0] mdl [4];
   logic [31:0] wm [4] = '{`OCC_SLOW_WMASK, 32'h0000009F, `OCC_FAST_WMASK,
      32'h00000FFE};
   int ofs [4] = '{24, 28, 32, 36};
   int fails = 0;
   int checks = 0;
   occ_osc_ctrl #(.NUM_REQ(NR), .FAST_SETTLE(8), .LOOP_SYNC(3)) i_dut (
      .sys_clk, .resetn, .clk_en, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .avs_response_err, .cal_ulp_trim, .cal_fast_trim, .cal_fast_range,
      .cal_valid, .standby, .wake_event, .slow_req, .fast_req, .loop_req,
      .loop_locked, .loop_clk_stopped, .slow_run, .slow_out_1k_enable,
      .slow_out_32k_enable, .ulp_trim_value, .fast_run, .fast_freq_range_sel,
      .fast_temp_trim, .fast_process_trim, .fast_div_factor, .loop_run,
      .loop_out_gate, .loop_closed, .loop_skip_coarse_lock, .loop_freeze_fine,
      .loop_quick_lock_off, .loop_chill_cycle_off, .loop_bus_clock_recovery,
      .loop_drop_locks);
   occ_req_model #(.NUM_REQ(NR)) i_req (.sys_clk, .resetn, .want, .slow_req,
      .fast_req, .loop_req);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask
   // holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [5:0] a,
         input logic [31:0] d, input logic [3:0] be);
      int n;
      logic w;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= ~wr;
      avs_write <= wr;
      n = 0;
      do begin
         @(posedge sys_clk);
         w = avs_waitrequest;
         rq = avs_readdata;
         eq = avs_response_err;
         n++;
      end while (w !== 1'b0 && n < 40);
      cmp_pin(w, 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input int i, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] m;
      m = wm[i] & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      if (!(i == 0 && mdl[0][12]) && !(i == 1 && mdl[1][7]))
         mdl[i] = (mdl[i] & ~m) | (d & m);
      bus(1'b1, 6'(ofs[i]), d & wm[i], be);
   endtask
   task automatic rd(input int i, input logic [31:0] exp);
      bus(1'b0, 6'(ofs[i]), 32'h0, 4'hF);
      cmp_word(rq, exp);
   endtask
   task automatic do_reset();
      @(posedge sys_clk);
      resetn <= 1'b0;
      cal_valid <= 1'b0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      mdl = '{32'h003F0080, 32'h0, 32'h00000382, 32'h00000080};
   endtask
   // c holds on-demand, keep-in-standby, standby and request, low bit first
   task automatic run_case(input int i, input logic [3:0] c);
      int j;
      logic got;
      j = i == 0 ? 0 : i + 1;
      wr(j, (mdl[j] & ~32'hCE) | {24'h0, c[0], c[1], 2'b0, 2'($urandom),
         2'b10}, 4'hF);
      standby <= c[2];
      want <= 3'(c[3]) << i;
      repeat (14) @(posedge sys_clk);
      er = (~c[0] | c[3]) & (~c[2] | c[1]);
      got = i == 0 ? slow_run : i == 1 ? fast_run : loop_run;
      cmp_pin(got, er);
      if (i == 0) cmp_pin(slow_out_1k_enable, er & mdl[0][3]);
      if (i == 0) cmp_pin(slow_out_32k_enable, er & mdl[0][2]);
      if (i == 2) cmp_pin(loop_out_gate, er & (~mdl[3][11] | loop_locked));
   endtask
   initial begin
      #400000;
      fails++;
      summarize();
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      {clk_en, resetn, avs_read, avs_write, cal_valid, standby} = 6'h20;
      {wake_event, loop_locked, loop_clk_stopped, want} = 6'h0;
      {avs_address, avs_writedata, avs_byteenable} = 42'h0;
      {cal_ulp_trim, cal_fast_trim, cal_fast_range} = 22'h0;
      void'($urandom(32'h133D47B7));
      do_reset();
      cal_ulp_trim <= 8'($urandom);
      cal_fast_trim <= 12'($urandom);
      cal_fast_range <= 2'($urandom);
      @(posedge sys_clk);
      cal_valid <= 1'b1;
      repeat (12) @(posedge sys_clk);
      mdl[1][4:0] = cal_ulp_trim[4:0];
      mdl[2][31:16] = {cal_fast_range, 2'b0, cal_fast_trim};
      for (int i = 0; i < 4; i++) rd(i, mdl[i]);
      $display("test reset values done");
      wr(2, mdl[2] & ~32'h2, 4'h1);
      rd(2, mdl[2] | 32'h2);
      repeat (12) @(posedge sys_clk);
      rd(2, mdl[2]);
      wr(2, mdl[2] | 32'h2, 4'h1);
      rd(2, mdl[2] & ~32'h2);
      repeat (12) @(posedge sys_clk);
      rd(2, mdl[2]);
      $display("test fast enable readback done");
      repeat (16) begin
         loop_locked <= 1'($urandom);
         wr(3, $urandom, 4'($urandom));
         rd(3, mdl[3]);
         wr(2, ($urandom & 32'hFFFFFF00) | (mdl[2] & 32'hFF), 4'($urandom));
         rd(2, mdl[2]);
         repeat (4) @(posedge sys_clk);
         cmp_word(32'(fast_div_factor), 32'h1 << mdl[2][9:8]);
         cmp_pin(loop_closed, mdl[3][2]);
         cmp_pin(loop_freeze_fine, mdl[3][3]);
         cmp_pin(loop_skip_coarse_lock, mdl[3][10]);
         cmp_pin(loop_quick_lock_off, mdl[3][9]);
         cmp_pin(loop_chill_cycle_off, mdl[3][8]);
         cmp_pin(loop_bus_clock_recovery, mdl[3][5]);
      end
      $display("test random fields done");
      for (int i = 0; i < 3; i++)
         for (int c = 0; c < 16; c++) run_case(i, 4'(c));
      $display("test on demand done");
      for (int c = 0; c < 4; c++) begin
         wr(3, (mdl[3] & ~32'h10) | (32'(c[0]) << 4), 4'h1);
         loop_clk_stopped <= c[1];
         wake_event <= 1'b1;
         @(posedge sys_clk);
         wake_event <= 1'b0;
         #1 cmp_pin(loop_drop_locks, c[0] & c[1]);
      end
      bus(1'b0, 6'h3C, 32'h0, 4'hF);
      cmp_pin(eq, 1'b1);
      cmp_word(rq, 32'h0);
      // frozen block must ignore a stopped-clock wake
      clk_en <= 1'b0;
      wake_event <= 1'b1;
      repeat (3) @(posedge sys_clk);
      cmp_pin(loop_drop_locks, 1'b0);
      {clk_en, wake_event} <= 2'b10;
      $display("test wake and unmapped done");
      wr(1, 32'h0000008A, 4'h1);
      wr(1, 32'h00000015, 4'h1);
      rd(1, mdl[1]);
      wr(0, mdl[0] | 32'h00001000, 4'hF);
      wr(0, 32'h00000004, 4'hF);
      rd(0, mdl[0]);
      do_reset();
      wr(1, 32'h00000015, 4'h1);
      rd(1, mdl[1]);
      wr(0, 32'h00000004, 4'h1);
      rd(0, mdl[0]);
      $display("test write lock done");
      summarize();
   end
endmodule
